// ===== rtl/pst_pkg.sv
// Constants, register map and state codes for the power state controller.
// Assumes a 200 MHz system clock; the fixed times are turned into cycle counts here.
package pst_pkg;
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int PS_PER_US       = 1000000;
	localparam int CYCLES_PER_US   = PS_PER_US / CLK_PERIOD_PS;
	localparam int SW_OFF_DELAY_US = 500;
	localparam int SW_OFF_CYCLES   = (SW_OFF_DELAY_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int XFAIL_SYNC_US   = 20;
	localparam int XFAIL_SYNC_CYC  = (XFAIL_SYNC_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PIN_HOLD_US     = 2000;
	localparam int PIN_HOLD_CYCLES = (PIN_HOLD_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TMR_W           = 20;
	localparam logic [1:0] SELFTEST_LAST = 2'h2;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_CFG    = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	localparam int CTRL_LP_SEL   = 0;
	localparam int CTRL_SW_OFF   = 1;
	localparam int CTRL_EDGE     = 2;
	localparam int CTRL_XF_EN    = 3;
	localparam int CTRL_OV_SDWN  = 4;
	localparam int CTRL_FS_BYP   = 5;
	localparam int CTRL_OV_DIS   = 6;
	localparam int CTRL_W        = 7;
	localparam logic [6:0] CTRL_RESET = 7'h00;
	localparam int CFG_DBNC_LSB  = 0;
	localparam int CFG_FLIM_LSB  = 8;
	localparam int CFG_FSLIM_LSB = 12;
	localparam int CFG_W         = 16;
	localparam logic [15:0] CFG_RESET = 16'h330A;
	localparam int STAT_FSCNT    = 4;
	localparam int STAT_TRIES    = 8;
	localparam int STAT_FLAGS    = 10;

	localparam int TMR_PIN = 0;
	localparam int TMR_SW  = 1;
	localparam int TMR_OV  = 2;
	localparam int TMR_XF  = 3;
	localparam int TMR_NUM = 4;

	localparam int SYN_POWER_ON_PIN = 0;
	localparam int SYN_XFAIL = 1;
	localparam int SYN_UV    = 2;
	localparam int SYN_OV    = 3;
	localparam int SYN_OT    = 4;
	localparam int SYN_TBB   = 5;
	localparam int SYN_NUM   = 6;

	typedef enum logic [3:0] {
		ST_LP_IDLE   = 4'h0,
		ST_SELF_TEST = 4'h1,
		ST_QPU_IDLE  = 4'h2,
		ST_POWER_UP  = 4'h3,
		ST_SYSTEM_ON = 4'h4,
		ST_PD_REQ    = 4'h5,
		ST_PD_FAULT  = 4'h6,
		ST_FS_TRANS  = 4'h7,
		ST_FS_LOCK   = 4'h8
	} pst_state_type;
endpackage : pst_pkg

// ===== rtl/pst_power_state_ctrl.sv
// Power state controller: off states, power-up handover, shutdowns, fail-safe.
// Assumes sequencer, self-test and fault monitors run on sys_clk; pins are asynchronous.
// Function
// - Quick-start idle passes to power-up when select 0, test mode off, flags clear.
// - Level mode: power-on pin high is a power-up request in quick-start idle.
// - Edge mode: a falling power-on pin is the power-up request.
// - Request starts power-up only with supply above undervoltage, below overvoltage unless CTRL_OV_DIS is set, and no overtemperature.
// - Power-up is blocked unless trim, config and self-test errors are all clear.
// - Test-board mode lets a valid request start power-up regardless of select.
// - With external fail enabled, the external fail input must be high to start.
// - Power-up hands over to system-on when processor reset is released.
// - Level mode: power-on pin low in system-on requests turn-off.
// - Edge mode: turn-off after falling pin held low longer than hold time.
// - Software turn-off request starts power-down after a 500 us timer.
// - Overvoltage beyond debounce time with shutdown enabled gives protective turn-off.
// - Enabled external fail going low gives turn-off after 20 us.
// - Fault timer, fault count limit or overtemperature in system-on gives fault power-down.
// - Requested power-down ends in low-power idle.
// - A power-up failure goes to fault power-down.
// - Third self-test failure with test-board mode low goes to fail-safe transition.
// - Fault power-down ends in the fail-safe transition.
// - Fail-safe transition returns to low-power idle when counter differs from limit or with bypass.
// - Fail-safe transition locks when counter equals limit and bypass is 0.
module pst_power_state_ctrl
	import pst_pkg::*;
#(
	parameter int SW_OFF_CYC   = SW_OFF_CYCLES,
	parameter int PIN_HOLD_CYC = PIN_HOLD_CYCLES
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	// Register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wrData,
	input  wire logic              wrStrobe,
	input  wire logic              rdStrobe,
	output logic      [DATA_W-1:0] rdData,
	// Asynchronous pins and comparators
	input  wire logic              powerOnPin,
	input  wire logic              externalFailInput,
	input  wire logic              testBoardModeEnable,
	input  wire logic              vinAboveUndervoltage,
	input  wire logic              vinAboveOvervoltage,
	input  wire logic              junctionOverTemp,
	// On-chip status
	input  wire logic              trimLoadError,
	input  wire logic              configLoadError,
	input  wire logic              selfTestDone,
	input  wire logic              selfTestPassed,
	input  wire logic              processorResetReleased,
	input  wire logic              powerUpFailure,
	input  wire logic              powerDownDone,
	input  wire logic              faultTimerExpired,
	input  wire logic [3:0]        faultCounter,
	// State outputs
	output logic                   selfTestRun,
	output logic                   powerUpRun,
	output logic                   systemOnActive,
	output logic                   powerDownRun,
	output logic                   faultShutdown,
	output logic                   failsafeLocked,
	output logic      [3:0]        stateCode
);
	pst_state_type state_ff;
	pst_state_type nxtState;
	logic [SYN_NUM-1:0] sync1_ff;
	logic [SYN_NUM-1:0] sync2_ff;
	logic               pinPrev_ff;
	logic               xfPrev_ff;
	logic               pinHoldArm_ff;
	logic               xfArm_ff;
	logic [CTRL_W-1:0]  ctrl_ff;
	logic [CFG_W-1:0]   cfg_ff;
	logic [DATA_W-1:0]  rdData_ff;
	logic [3:0]         failsafeCounter_ff;
	logic [1:0]         tries_ff;
	logic               selftestError_ff;
	logic               startPending_ff;
	logic [5:0]         outs_ff;
	logic [TMR_W-1:0]   tmrCnt_ff [TMR_NUM];
	logic [TMR_W-1:0]   tmrLimit  [TMR_NUM];
	logic [TMR_NUM-1:0] tmrArm;
	logic [TMR_NUM-1:0] tmrDone;

	function automatic logic [5:0] stateOuts(input pst_state_type st);
		stateOuts = {st == ST_FS_LOCK, st == ST_PD_FAULT, st == ST_PD_REQ || st == ST_PD_FAULT,
			st == ST_SYSTEM_ON, st == ST_POWER_UP, st == ST_SELF_TEST};
	endfunction : stateOuts

	// Two flops on every asynchronous input; only the second flop is read.
	always_ff @(posedge sys_clk) begin
		sync1_ff <= {testBoardModeEnable, junctionOverTemp, vinAboveOvervoltage,
			vinAboveUndervoltage, externalFailInput, powerOnPin};
		sync2_ff <= sync1_ff;
	end

	wire pinHigh   = sync2_ff[SYN_POWER_ON_PIN];
	wire xfHigh    = sync2_ff[SYN_XFAIL];
	wire tbb       = sync2_ff[SYN_TBB];
	wire overTemp  = sync2_ff[SYN_OT];
	wire ovDetect  = sync2_ff[SYN_OV];
	wire lpSel     = ctrl_ff[CTRL_LP_SEL];
	wire edgeMode  = ctrl_ff[CTRL_EDGE];
	wire xfEnable  = ctrl_ff[CTRL_XF_EN];
	wire pinFall   = pinPrev_ff & ~pinHigh;
	wire xfFall    = xfPrev_ff & ~xfHigh;
	wire inOn      = state_ff == ST_SYSTEM_ON;

	wire powerReq  = edgeMode ? pinFall : pinHigh;
	wire supplyOk  = sync2_ff[SYN_UV] & (ctrl_ff[CTRL_OV_DIS] | ~ovDetect) & ~overTemp;
	wire loadOk    = ~trimLoadError & ~configLoadError;
	wire flagsOk   = loadOk & ~selftestError_ff;
	wire xfailOk   = ~xfEnable | xfHigh;
	wire passThru  = startPending_ff & ~lpSel & ~tbb & flagsOk & xfailOk;
	wire reqStart  = (lpSel | tbb) & powerReq & supplyOk & flagsOk & xfailOk;
	wire startOk   = passThru | reqStart;
	wire faultNow  = faultTimerExpired | (faultCounter == cfg_ff[CFG_FLIM_LSB +: 4]) | overTemp;
	wire levelOff  = ~edgeMode & ~pinHigh;
	wire turnOff   = levelOff | (|tmrDone);
	wire lastTry   = tries_ff == SELFTEST_LAST;
	wire stFail    = state_ff == ST_SELF_TEST && selfTestDone && !selfTestPassed;
	wire fsLock    = failsafeCounter_ff == cfg_ff[CFG_FSLIM_LSB +: 4] && !ctrl_ff[CTRL_FS_BYP];
	wire fsEntry   = nxtState == ST_FS_TRANS && state_ff != ST_FS_TRANS;
	wire fsCntMax  = failsafeCounter_ff == 4'hF;

	always_comb begin
		nxtState = state_ff;
		unique case (state_ff)
			ST_LP_IDLE: begin
				if (lpSel || tbb || (powerReq && loadOk && supplyOk))
					nxtState = ST_SELF_TEST;
			end
			ST_SELF_TEST: begin
				if (selfTestDone && selfTestPassed)
					nxtState = ST_QPU_IDLE;
				else if (stFail && lastTry)
					nxtState = tbb ? ST_QPU_IDLE : ST_FS_TRANS;
			end
			ST_QPU_IDLE: begin
				if (startOk)
					nxtState = ST_POWER_UP;
			end
			ST_POWER_UP: begin
				if (powerUpFailure)
					nxtState = ST_PD_FAULT;
				else if (processorResetReleased)
					nxtState = ST_SYSTEM_ON;
			end
			ST_SYSTEM_ON: begin
				if (faultNow)
					nxtState = ST_PD_FAULT;
				else if (turnOff)
					nxtState = ST_PD_REQ;
			end
			ST_PD_REQ: begin
				if (powerDownDone)
					nxtState = ST_LP_IDLE;
			end
			ST_PD_FAULT: begin
				if (powerDownDone)
					nxtState = ST_FS_TRANS;
			end
			ST_FS_TRANS: nxtState = fsLock ? ST_FS_LOCK : ST_LP_IDLE;
			ST_FS_LOCK: nxtState = ST_FS_LOCK;
			default: nxtState = ST_LP_IDLE;
		endcase
	end

	// Turn-off timers; each restarts whenever its cause drops or system-on is left.
	assign tmrArm[TMR_PIN] = inOn & edgeMode & pinHoldArm_ff & ~pinHigh;
	assign tmrArm[TMR_SW]  = inOn & ctrl_ff[CTRL_SW_OFF];
	assign tmrArm[TMR_OV]  = inOn & ctrl_ff[CTRL_OV_SDWN] & ovDetect;
	assign tmrArm[TMR_XF]  = inOn & xfEnable & xfArm_ff & ~xfHigh;
	assign tmrLimit[TMR_PIN] = TMR_W'(PIN_HOLD_CYC);
	assign tmrLimit[TMR_SW]  = TMR_W'(SW_OFF_CYC);
	// Both factors are widened first, so the cycle count is not cut to eight bits.
	assign tmrLimit[TMR_OV]  = TMR_W'(cfg_ff[CFG_DBNC_LSB +: 8]) * TMR_W'(CYCLES_PER_US);
	assign tmrLimit[TMR_XF]  = TMR_W'(XFAIL_SYNC_CYC);

	genvar gi;
	generate
		for (gi = 0; gi < TMR_NUM; gi++) begin : gTmr
			assign tmrDone[gi] = tmrArm[gi] && tmrCnt_ff[gi] >= tmrLimit[gi];
			always_ff @(posedge sys_clk) begin
				if (!resetn || !tmrArm[gi])
					tmrCnt_ff[gi] <= '0;
				else if (!tmrDone[gi])
					tmrCnt_ff[gi] <= tmrCnt_ff[gi] + TMR_W'(1);
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pinPrev_ff    <= 1'b0;
			xfPrev_ff     <= 1'b0;
			pinHoldArm_ff <= 1'b0;
			xfArm_ff      <= 1'b0;
		end else begin
			pinPrev_ff    <= pinHigh;
			xfPrev_ff     <= xfHigh;
			pinHoldArm_ff <= inOn & (pinFall | (pinHoldArm_ff & ~pinHigh));
			xfArm_ff      <= inOn & (xfFall | (xfArm_ff & ~xfHigh));
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_ff <= ST_LP_IDLE;
			outs_ff  <= 6'h00;
		end else begin
			state_ff <= nxtState;
			outs_ff  <= stateOuts(nxtState);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			tries_ff         <= 2'h0;
			selftestError_ff <= 1'b0;
			startPending_ff  <= 1'b0;
		end else begin
			if (state_ff == ST_LP_IDLE)
				tries_ff <= 2'h0;
			else if (stFail && !lastTry)
				tries_ff <= tries_ff + 2'h1;
			if (state_ff == ST_SELF_TEST && selfTestDone)
				selftestError_ff <= ~selfTestPassed;
			if (state_ff == ST_LP_IDLE && nxtState == ST_SELF_TEST)
				startPending_ff <= ~lpSel & ~tbb;
			else if (state_ff == ST_QPU_IDLE && nxtState != ST_QPU_IDLE)
				startPending_ff <= 1'b0;
		end
	end

	// The counter is kept over fail-safe returns; only reset clears it.
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			failsafeCounter_ff <= 4'h0;
		else if (fsEntry && !fsCntMax)
			failsafeCounter_ff <= failsafeCounter_ff + 4'h1;
	end

	// Register port. A software turn-off write in the cycle the request is retired wins.
	wire selCtrl = addr == ADDR_CTRL;
	wire selCfg  = addr == ADDR_CFG;
	wire selStat = addr == ADDR_STATUS;
	wire swClear = state_ff == ST_SYSTEM_ON && nxtState != ST_SYSTEM_ON;
	wire [DATA_W-1:0] statusWord = {18'h0_0000, outs_ff[5], selftestError_ff, configLoadError,
		trimLoadError, tries_ff, failsafeCounter_ff, 4'(state_ff)};
	wire [DATA_W-1:0] rdMux = selCtrl ? DATA_W'(ctrl_ff) : selCfg ? DATA_W'(cfg_ff) :
		selStat ? statusWord : 32'h0000_0000;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ctrl_ff   <= CTRL_RESET;
			cfg_ff    <= CFG_RESET;
			rdData_ff <= 32'h0000_0000;
		end else begin
			if (wrStrobe && selCtrl)
				ctrl_ff <= wrData[CTRL_W-1:0];
			else if (swClear)
				ctrl_ff[CTRL_SW_OFF] <= 1'b0;
			if (wrStrobe && selCfg)
				cfg_ff <= wrData[CFG_W-1:0];
			rdData_ff <= rdStrobe ? rdMux : 32'h0000_0000;
		end
	end

	assign rdData         = rdData_ff;
	assign selfTestRun    = outs_ff[0];
	assign powerUpRun     = outs_ff[1];
	assign systemOnActive = outs_ff[2];
	assign powerDownRun   = outs_ff[3];
	assign faultShutdown  = outs_ff[4];
	assign failsafeLocked = outs_ff[5];
	assign stateCode      = 4'(state_ff);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence fsEnter;
		state_ff != ST_FS_TRANS ##1 state_ff == ST_FS_TRANS;
	endsequence
	sequence onHold(logic c);
		inOn && c && !faultNow;
	endsequence

	pass_thru_a: assert property (state_ff == ST_QPU_IDLE && startPending_ff && !lpSel && !tbb && flagsOk
		&& xfailOk |=> state_ff == ST_POWER_UP) else $error("pass-through missed");
	level_req_a: assert property (state_ff == ST_QPU_IDLE && lpSel && !edgeMode && pinHigh && supplyOk
		&& flagsOk && xfailOk |=> state_ff == ST_POWER_UP) else $error("level request missed");
	edge_req_a: assert property (state_ff == ST_QPU_IDLE && lpSel && edgeMode && pinFall && supplyOk
		&& flagsOk && xfailOk |=> state_ff == ST_POWER_UP) else $error("edge request missed");
	supply_gate_a: assert property (state_ff == ST_QPU_IDLE && !passThru && !supplyOk
		|=> state_ff == ST_QPU_IDLE) else $error("start with bad supply");
	flag_gate_a: assert property (state_ff == ST_QPU_IDLE && !flagsOk |=> state_ff == ST_QPU_IDLE)
		else $error("start with error flag");
	xfail_gate_a: assert property (state_ff == ST_QPU_IDLE && xfEnable && !xfHigh
		|=> state_ff == ST_QPU_IDLE) else $error("start with fail low");
	handover_a: assert property (state_ff == ST_POWER_UP && processorResetReleased && !powerUpFailure
		|=> state_ff == ST_SYSTEM_ON && systemOnActive) else $error("no system-on");
	level_off_a: assert property (onHold(levelOff) |=> state_ff == ST_PD_REQ && powerDownRun)
		else $error("level turn-off missed");
	sw_wait_a: assert property (onHold(!levelOff && tmrDone == 4'h0) |=> state_ff == ST_SYSTEM_ON)
		else $error("early turn-off");
	fault_off_a: assert property (inOn && faultNow |=> state_ff == ST_PD_FAULT && faultShutdown)
		else $error("fault power-down missed");
	req_end_a: assert property (state_ff == ST_PD_REQ && powerDownDone |=> state_ff == ST_LP_IDLE)
		else $error("requested off not idle");
	fault_end_a: assert property (state_ff == ST_PD_FAULT && powerDownDone |=> state_ff == ST_FS_TRANS)
		else $error("fault off not fail-safe");
	fs_lock_a: assert property (state_ff == ST_FS_TRANS |=> state_ff == ($past(fsLock) ? ST_FS_LOCK
		: ST_LP_IDLE)) else $error("fail-safe exit wrong");
	fs_count_a: assert property (fsEnter |-> failsafeCounter_ff == ($past(failsafeCounter_ff, 1) == 4'hF
		? 4'hF : $past(failsafeCounter_ff, 1) + 4'h1)) else $error("fail-safe count wrong");
endmodule : pst_power_state_ctrl

// ===== verification/pst_host_model.sv
// Host side partner: drives the power-on pin and the external fail input.
// Assumes the bench calls its tasks; every change lands just after a rising clock edge.
module pst_host_model (
	// Clock
	input  wire logic sys_clk,
	// Pins toward the controller
	output logic      powerOnPin,
	output logic      externalFailInput
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		powerOnPin        = 1'h0;
		externalFailInput = 1'h1;
	end

	// A lag of zero answers promptly; a larger lag models a slow host.
	task automatic drive(input logic pin, input logic xf, input int lag);
		repeat (lag) @(posedge sys_clk);
		@(posedge sys_clk);
		powerOnPin        <= pin;
		externalFailInput <= xf;
	endtask : drive

	// Holds the pin low for len+1 cycles, then lets it return high.
	task automatic pulseLow(input int len);
		drive(1'h0, externalFailInput, 0);
		drive(1'h1, externalFailInput, len);
	endtask : pulseLow
endmodule : pst_host_model

// ===== verification/testbench.sv
// Bench for the power state controller: one task per scenario, each judged on the spot.
// Assumes the controller and the host model; the software-off and pin-hold timers are shortened by parameters.
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module testbench
	import pst_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int SWC   = 20;
	localparam int PHC   = 16;
	localparam int LIMIT = 20000;
	localparam int EV_REL = 0, EV_FAIL = 1, EV_DONE = 2, EV_TMR = 3;

	logic              sys_clk = 1'h0;
	logic              resetn = 1'h0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wrData = '0;
	logic [DATA_W-1:0] rdData;
	logic              wrStrobe = 1'h0, rdStrobe = 1'h0;
	logic              powerOnPin, externalFailInput;
	logic              testBoardModeEnable = 1'h0, vinAboveUndervoltage = 1'h1;
	logic              vinAboveOvervoltage = 1'h0, junctionOverTemp = 1'h0;
	logic              trimLoadError = 1'h0, configLoadError = 1'h0;
	logic              selfTestDone = 1'h0, selfTestPassed = 1'h0;
	logic [3:0]        seqEvent = 4'h0, faultCounter = 4'h0, stateCode;
	logic              selfTestRun, powerUpRun, systemOnActive, powerDownRun, faultShutdown, failsafeLocked;
	int                n_fail = 0, check_count = 0, cycles = 0;

	always #2.5 sys_clk = ~sys_clk;

	pst_power_state_ctrl #(.SW_OFF_CYC(SWC), .PIN_HOLD_CYC(PHC)) u_pst_power_state_ctrl (
		.sys_clk, .resetn, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .powerOnPin, .externalFailInput,
		.testBoardModeEnable, .vinAboveUndervoltage, .vinAboveOvervoltage, .junctionOverTemp,
		.trimLoadError, .configLoadError, .selfTestDone, .selfTestPassed,
		.processorResetReleased(seqEvent[EV_REL]), .powerUpFailure(seqEvent[EV_FAIL]),
		.powerDownDone(seqEvent[EV_DONE]), .faultTimerExpired(seqEvent[EV_TMR]), .faultCounter,
		.selfTestRun, .powerUpRun, .systemOnActive, .powerDownRun, .faultShutdown, .failsafeLocked, .stateCode
	);

	pst_host_model u_pst_host_model (.sys_clk, .powerOnPin, .externalFailInput);

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr     <= a;
		wrData   <= d;
		wrStrobe <= 1'h1;
		@(posedge sys_clk);
		wrStrobe <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr     <= a;
		rdStrobe <= 1'h1;
		@(posedge sys_clk);
		rdStrobe <= 1'h0;
		#1 d = rdData;
	endtask : rd

	task automatic pulse(input int k);
		@(posedge sys_clk);
		seqEvent[k] <= 1'h1;
		@(posedge sys_clk);
		seqEvent[k] <= 1'h0;
	endtask : pulse

	task automatic stDone(input logic pass);
		@(posedge sys_clk);
		selfTestPassed <= pass;
		selfTestDone   <= 1'h1;
		@(posedge sys_clk);
		selfTestDone   <= 1'h0;
	endtask : stDone

	// Bounded wait, since a stuck state machine must not hang the run.
	task automatic waitSt(input logic [3:0] s, input int lim);
		int i;
		i = 0;
		#1;
		while (stateCode !== s && i < lim) begin
			tick(1);
			i++;
		end
		`CHK(stateCode, s)
	endtask : waitSt

	task automatic doReset();
		@(posedge sys_clk);
		resetn <= 1'h0;
		{trimLoadError, configLoadError, junctionOverTemp, vinAboveOvervoltage, testBoardModeEnable} <= 5'h00;
		u_pst_host_model.drive(1'h0, 1'h1, 0);
		repeat (20) @(posedge sys_clk);
		resetn <= 1'h1;
		tick(2);
		`CHK(stateCode, ST_LP_IDLE)
	endtask : doReset

	task automatic toQpu(input logic [31:0] ctrl);
		wr(ADDR_CTRL, ctrl);
		waitSt(ST_SELF_TEST, 10);
		`CHK(selfTestRun, 1'h1)
		stDone(1'h1);
		waitSt(ST_QPU_IDLE, 5);
	endtask : toQpu

	task automatic bringUp(input logic [31:0] ctrl);
		toQpu(ctrl);
		u_pst_host_model.drive(1'h1, 1'h1, 0);
		waitSt(ST_POWER_UP, 8);
		pulse(EV_REL);
		waitSt(ST_SYSTEM_ON, 4);
		`CHK(systemOnActive, 1'h1)
	endtask : bringUp

	task automatic t_level();
		logic [31:0] d;
		doReset();
		rd(ADDR_CFG, d);
		`CHK(d, {16'h0000, CFG_RESET})
		rd(8'h0C, d);
		`CHK(d, 32'h0000_0000)
		toQpu(32'h0000_0001);
		@(posedge sys_clk);
		configLoadError <= 1'h1;
		u_pst_host_model.drive(1'h1, 1'h1, 0);
		tick(8);
		`CHK(stateCode, ST_QPU_IDLE)
		@(posedge sys_clk);
		junctionOverTemp <= 1'h1;
		tick(4);
		@(posedge sys_clk);
		configLoadError <= 1'h0;
		tick(8);
		`CHK(stateCode, ST_QPU_IDLE)
		@(posedge sys_clk);
		junctionOverTemp <= 1'h0;
		waitSt(ST_POWER_UP, 6);
		`CHK(powerUpRun, 1'h1)
		pulse(EV_REL);
		waitSt(ST_SYSTEM_ON, 4);
		u_pst_host_model.drive(1'h0, 1'h1, 3);
		waitSt(ST_PD_REQ, 8);
		`CHK(powerDownRun, 1'h1)
		wr(ADDR_CTRL, 32'h0000_0000);
		pulse(EV_DONE);
		waitSt(ST_LP_IDLE, 4);
		$display("test level done");
	endtask : t_level

	task automatic t_pass();
		doReset();
		wr(ADDR_CTRL, 32'h0000_0004);
		u_pst_host_model.drive(1'h1, 1'h1, 0);
		tick(6);
		`CHK(stateCode, ST_LP_IDLE)
		u_pst_host_model.drive(1'h0, 1'h1, 0);
		waitSt(ST_SELF_TEST, 8);
		stDone(1'h1);
		waitSt(ST_POWER_UP, 4);
		$display("test pass-through done");
	endtask : t_pass

	task automatic t_edge();
		doReset();
		u_pst_host_model.drive(1'h1, 1'h1, 0);
		toQpu(32'h0000_0005);
		tick(8);
		`CHK(stateCode, ST_QPU_IDLE)
		u_pst_host_model.drive(1'h0, 1'h1, 0);
		waitSt(ST_POWER_UP, 8);
		pulse(EV_REL);
		u_pst_host_model.drive(1'h1, 1'h1, 0);
		tick(4);
		u_pst_host_model.pulseLow(PHC - 8);
		tick(PHC);
		`CHK(stateCode, ST_SYSTEM_ON)
		u_pst_host_model.pulseLow(PHC + 12);
		waitSt(ST_PD_REQ, 8);
		$display("test edge done");
	endtask : t_edge

	task automatic t_offs();
		doReset();
		bringUp(32'h0000_0001);
		wr(ADDR_CTRL, 32'h0000_0003);
		tick(SWC - 4);
		`CHK(stateCode, ST_SYSTEM_ON)
		waitSt(ST_PD_REQ, 10);
		doReset();
		wr(ADDR_CFG, 32'h0000_3301);
		bringUp(32'h0000_0011);
		@(posedge sys_clk);
		vinAboveOvervoltage <= 1'h1;
		tick(150);
		`CHK(stateCode, ST_SYSTEM_ON)
		waitSt(ST_PD_REQ, 80);
		$display("test software and overvoltage off done");
	endtask : t_offs

	task automatic t_xfail();
		doReset();
		u_pst_host_model.drive(1'h0, 1'h0, 0);
		toQpu(32'h0000_0009);
		u_pst_host_model.drive(1'h1, 1'h0, 0);
		tick(10);
		`CHK(stateCode, ST_QPU_IDLE)
		u_pst_host_model.drive(1'h1, 1'h1, 2);
		waitSt(ST_POWER_UP, 8);
		pulse(EV_REL);
		u_pst_host_model.drive(1'h1, 1'h0, 0);
		tick(3900);
		`CHK(stateCode, ST_SYSTEM_ON)
		waitSt(ST_PD_REQ, 200);
		$display("test external fail done");
	endtask : t_xfail

	task automatic t_fault();
		logic [31:0] d;
		doReset();
		wr(ADDR_CFG, 32'h0000_430A);
		for (int i = 0; i < 4; i++) begin
			u_pst_host_model.drive(1'h0, 1'h1, 0);
			toQpu(32'h0000_0001);
			u_pst_host_model.drive(1'h1, 1'h1, 0);
			waitSt(ST_POWER_UP, 8);
			if (i == 0)
				pulse(EV_FAIL);
			else begin
				pulse(EV_REL);
				@(posedge sys_clk);
				if (i == 1)
					seqEvent[EV_TMR] <= 1'h1;
				else if (i == 2)
					faultCounter <= 4'h3;
				else
					junctionOverTemp <= 1'h1;
			end
			waitSt(ST_PD_FAULT, 6);
			`CHK(faultShutdown, 1'h1)
			@(posedge sys_clk);
			{junctionOverTemp, faultCounter, seqEvent[EV_TMR]} <= 6'h00;
			pulse(EV_DONE);
			waitSt(ST_FS_TRANS, 3);
			waitSt((i < 3) ? ST_LP_IDLE : ST_FS_LOCK, 3);
			rd(ADDR_STATUS, d);
			`CHK(d[7:4], 4'(i + 1))
		end
		`CHK(failsafeLocked, 1'h1)
		$display("test fault path done");
	endtask : t_fault

	task automatic t_selftest();
		doReset();
		wr(ADDR_CTRL, 32'h0000_0001);
		waitSt(ST_SELF_TEST, 10);
		repeat (3) stDone(1'h0);
		waitSt(ST_FS_TRANS, 3);
		waitSt(ST_LP_IDLE, 3);
		doReset();
		@(posedge sys_clk);
		testBoardModeEnable <= 1'h1;
		waitSt(ST_SELF_TEST, 10);
		stDone(1'h1);
		waitSt(ST_QPU_IDLE, 5);
		u_pst_host_model.drive(1'h1, 1'h1, 0);
		waitSt(ST_POWER_UP, 8);
		$display("test self-test and board mode done");
	endtask : t_selftest

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// The whole run needs under 5000 cycles, so this ceiling only trips on a hang.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_fail++;
			$display("ERROR %0t: timeout", $time);
			stop_test();
		end
	end

	initial begin
		t_level();
		t_pass();
		t_edge();
		t_offs();
		t_xfail();
		t_fault();
		t_selftest();
		stop_test();
	end
endmodule : testbench
